// ### hdl/spi_flash_front_end.sv
`timescale 1ns/10ps
// Functional notes
// - Output data changes after each falling serial clock edge.
// - Dual-input program samples the output pin as second input on rising edges.
// - Instruction, address and write data sampled from input pin on rising edges.
// - Dual-output fast read drives the input pin too, changing on falling edges.
// - Select high: deselected, output high impedance, standby unless busy.
// - Select low: selected and in active power state.
// - No instruction starts before a select falling edge after power-up.
// - Pause: outputs high impedance, clock and input ignored, still selected.
// - Write-protect pin low with srwd set freezes the block-protect bits.
// - Modes 0 and 3: sample on rising, drive on falling edges.
// - Page program writes up to 256 bytes within one page, one-to-zero only.
// - Dual-input program takes up to 256 bytes, two bits per clock.
// - Erases set range to FFh: subsector, sector or whole array.
// - Busy bit set during status write, OTP write, program or erase.
// - After deselect stay active until internal cycle ends, then standby.
// - Deep sleep instruction enters deep power-down until wake instruction.
// - In deep power-down all write, program and erase instructions ignored.
// - Modifying instructions accepted only with clock count a multiple of eight.
// - Modifying instructions need the write enable latch; it clears when the instruction commits at select rise.
module spi_flash_front_end (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic serial_in_io0_i,
	output logic serial_in_io0_o,
	output logic serial_in_io0_oe,
	input wire logic serial_out_io1_i,
	output logic serial_out_io1_o,
	output logic serial_out_io1_oe,
	input wire logic core_busy,
	input wire logic [7:0] rd_data,
	output logic [23:0] rd_addr,
	output logic frame_start,
	output logic wr_valid,
	output spi_flash_pkg::wr_byte_t wr_byte,
	output logic op_valid,
	output spi_flash_pkg::mem_op_t op,
	output logic [7:0] status,
	output spi_flash_pkg::power_t power_state
);
	import spi_flash_pkg::*;

	pins_t pins_s;
	logic sclk_q, cs_q, armed_q;
	logic selected, paused, rise_ok, fall_ok, cs_fall, cs_rise;
	phase_t phase_q, phase_d;
	logic [7:0] cmd_q, sh_in_q, sh_out_q, in_byte, stat_in_q;
	logic [2:0] cnt_q, pulse_q, bp_q;
	logic [3:0] cnt_sum;
	logic [1:0] bc_q;
	logic [23:0] addr_q;
	logic ok_q, data_seen_q, load_q, wel_q, deep_q, srwd_q;
	logic dual, byte_done, busy_flag, commit, allowed;

	// Maps an instruction to the memory operation it starts
	function automatic op_kind_t op_of(input logic [7:0] c);
		case (c)
			page_program_cmd, dual_input_program: op_of = op_page_prog;
			otp_program_cmd: op_of = op_otp_prog;
			subsector_erase_cmd: op_of = op_subsector_erase;
			sector_erase_cmd: op_of = op_sector_erase;
			whole_array_erase_cmd: op_of = op_array_erase;
			status_write_cmd: op_of = op_status_write;
			default: op_of = op_none;
		endcase
	endfunction

	// Pins come from the host's domain, so all pass two flops first
	pin_sync #(.W($bits(pins_t)), .INIT(pins_idle)) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.d({cs_n, sclk, hold_n, wp_n, serial_in_io0_i, serial_out_io1_i}),
		.sync_q(pins_s)
	);

	// Edge history of the synchronised clock and select
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
		end else begin
			sclk_q <= pins_s.sclk;
			cs_q <= pins_s.cs_n;
		end
	end

	// Only edges matter, so idle level of either mode is harmless
	assign cs_fall = cs_q & ~pins_s.cs_n;
	assign cs_rise = ~cs_q & pins_s.cs_n;
	assign selected = armed_q & ~pins_s.cs_n;
	assign paused = selected & ~pins_s.hold_n;
	assign rise_ok = selected & ~paused & pins_s.sclk & ~sclk_q;
	assign fall_ok = selected & ~paused & ~pins_s.sclk & sclk_q;

	// Power-up leaves the port deaf until select has fallen once
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			armed_q <= 1'b0;
			frame_start <= 1'b0;
		end else begin
			if (cs_fall) begin
				armed_q <= 1'b1;
			end
			frame_start <= cs_fall;
		end
	end

	// Two bits per clock in either dual data phase
	assign dual = (phase_q == ph_din && cmd_q == dual_input_program) ||
		(phase_q == ph_dout && cmd_q == dual_output_fast_read);
	assign cnt_sum = {1'b0, cnt_q} + (dual ? 4'h2 : 4'h1);
	assign byte_done = rise_ok & cnt_sum[3];
	// MSB arrives first; in dual mode io1 carries the higher bit
	assign in_byte = dual ? {sh_in_q[5:0], pins_s.io1, pins_s.io0} :
		{sh_in_q[6:0], pins_s.io0};
	assign busy_flag = core_busy | op_valid;
	assign allowed = deep_q ? (in_byte == wake_from_deep_sleep_cmd) :
		!(op_of(in_byte) != op_none && (!wel_q || busy_flag));

	// Phase sequencing at each completed byte
	always_comb begin
		phase_d = phase_q;
		if (byte_done) begin
			unique case (phase_q)
				ph_cmd: begin
					if (!allowed) begin
						phase_d = ph_done;
					end else begin
						case (in_byte)
							read_status_cmd: phase_d = ph_dout;
							status_write_cmd: phase_d = ph_din;
							read_cmd, fast_read_cmd, dual_output_fast_read,
							page_program_cmd, dual_input_program, otp_program_cmd,
							subsector_erase_cmd, sector_erase_cmd: phase_d = ph_addr;
							default: phase_d = ph_done;
						endcase
					end
				end
				ph_addr: begin
					if (bc_q == 2'(addr_bytes - 1)) begin
						case (cmd_q)
							fast_read_cmd, dual_output_fast_read: phase_d = ph_dummy;
							read_cmd: phase_d = ph_dout;
							page_program_cmd, dual_input_program,
							otp_program_cmd: phase_d = ph_din;
							default: phase_d = ph_done;
						endcase
					end
				end
				ph_dummy: phase_d = ph_dout;
				ph_din: phase_d = (cmd_q == status_write_cmd) ? ph_done : ph_din;
				ph_dout: phase_d = ph_dout;
				ph_done: phase_d = ph_done;
				default: phase_d = ph_done;
			endcase
		end
	end

	// Receive side; a frame cut short simply discards its state
	always_ff @(posedge clk_sys) begin
		if (srst || !selected) begin
			phase_q <= ph_cmd;
			cmd_q <= 8'h00;
			sh_in_q <= 8'h00;
			cnt_q <= 3'h0;
			pulse_q <= 3'h0;
			bc_q <= 2'h0;
			ok_q <= 1'b0;
			data_seen_q <= 1'b0;
			stat_in_q <= 8'h00;
			addr_q <= 24'h00_0000;
		end else if (rise_ok) begin
			pulse_q <= pulse_q + 3'h1;
			sh_in_q <= in_byte;
			cnt_q <= cnt_sum[2:0];
			phase_q <= phase_d;
			if (byte_done) begin
				if (phase_q == ph_cmd) begin
					cmd_q <= in_byte;
					ok_q <= allowed;
				end
				if (phase_q == ph_addr) begin
					addr_q <= {addr_q[15:0], in_byte};
					bc_q <= bc_q + 2'h1;
				end
				if (phase_q == ph_din) begin
					data_seen_q <= 1'b1;
					stat_in_q <= in_byte;
					// Offset wraps inside the page, so the last 256 bytes win
					addr_q[7:0] <= addr_q[7:0] + 8'h01;
				end
			end
		end
	end

	// Program data leaves as one pulse per byte; commit comes at frame end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_valid <= 1'b0;
			wr_byte <= '0;
		end else begin
			wr_valid <= byte_done && phase_q == ph_din && ok_q &&
				cmd_q != status_write_cmd;
			if (byte_done && phase_q == ph_din) begin
				wr_byte <= '{addr: addr_q, data: in_byte};
			end
		end
	end

	// Read address follows the address phase, then steps per byte sent
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_addr <= 24'h00_0000;
			load_q <= 1'b0;
		end else begin
			load_q <= byte_done && phase_d == ph_dout;
			if (byte_done && phase_q == ph_addr) begin
				rd_addr <= {addr_q[15:0], in_byte};
			end else if (load_q && cmd_q != read_status_cmd) begin
				rd_addr <= rd_addr + 24'h00_0001;
			end
		end
	end

	// Transmit side. The load lands one cycle after the last rising edge,
	// so the serial clock half period must exceed one system clock.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sh_out_q <= 8'h00;
			serial_out_io1_o <= 1'b0;
			serial_in_io0_o <= 1'b0;
		end else if (load_q) begin
			sh_out_q <= (cmd_q == read_status_cmd) ? status : rd_data;
		end else if (fall_ok && phase_q == ph_dout) begin
			serial_out_io1_o <= sh_out_q[7];
			if (cmd_q == dual_output_fast_read) begin
				serial_in_io0_o <= sh_out_q[6];
				sh_out_q <= {sh_out_q[5:0], 2'b00};
			end else begin
				sh_out_q <= {sh_out_q[6:0], 1'b0};
			end
		end
	end

	// Pins float unless selected, not paused and sending
	assign serial_out_io1_oe = selected & ~paused & (phase_q == ph_dout);
	assign serial_in_io0_oe = serial_out_io1_oe & (cmd_q == dual_output_fast_read);

	// An instruction executes only on a clean select rise
	assign commit = cs_rise && armed_q && ok_q && pulse_q == 3'h0 && cnt_q == 3'h0 &&
		(phase_q == ph_done || data_seen_q) &&
		!(op_of(cmd_q) != op_none && busy_flag);

	// Write enable latch and deep sleep
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wel_q <= 1'b0;
			deep_q <= 1'b0;
		end else if (commit) begin
			if (cmd_q == write_enable_cmd) begin
				wel_q <= 1'b1;
			end else if (cmd_q == write_disable_cmd || op_of(cmd_q) != op_none) begin
				wel_q <= 1'b0;
			end
			if (cmd_q == deep_sleep_cmd) begin
				deep_q <= 1'b1;
			end else if (cmd_q == wake_from_deep_sleep_cmd) begin
				deep_q <= 1'b0;
			end
		end
	end

	// Protect bits; a low write-protect pin with srwd set freezes them
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bp_q <= bp_reset;
			srwd_q <= srwd_reset;
		end else if (commit && cmd_q == status_write_cmd && !(srwd_q && !pins_s.wp_n)) begin
			bp_q <= stat_in_q[st_bp_lsb +: 3];
			srwd_q <= stat_in_q[st_srwd_bit];
		end
	end

	// Operation handed to the memory core, which runs the timed cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			op_valid <= 1'b0;
			op <= '0;
		end else begin
			op_valid <= commit && op_of(cmd_q) != op_none;
			if (commit) begin
				op <= '{kind: op_of(cmd_q), addr: addr_q, data: stat_in_q};
			end
		end
	end

	// Status byte as read back, and power state
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			status <= 8'h00;
			power_state <= pwr_standby;
		end else begin
			status <= 8'h00;
			status[st_busy_bit] <= busy_flag;
			status[st_wel_bit] <= wel_q;
			status[st_bp_lsb +: 3] <= bp_q;
			status[st_srwd_bit] <= srwd_q;
			if (deep_q) begin
				power_state <= pwr_deep;
			end else if (selected || busy_flag) begin
				power_state <= pwr_active;
			end else begin
				power_state <= pwr_standby;
			end
		end
	end

	property p_out_fall;
		@(posedge clk_sys) disable iff (srst)
		$changed(serial_out_io1_o) |-> $past(fall_ok);
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("output moved off a falling edge");

	property p_dual_in;
		@(posedge clk_sys) disable iff (srst)
		rise_ok && phase_q == ph_din && cmd_q == dual_input_program |=>
			sh_in_q[1] == $past(pins_s.io1) && sh_in_q[0] == $past(pins_s.io0);
	endproperty
	a_dual_in: assert property (p_dual_in) else $error("dual input bits lost");

	property p_cmd_sample;
		@(posedge clk_sys) disable iff (srst)
		rise_ok && phase_q == ph_cmd |=> sh_in_q[0] == $past(pins_s.io0);
	endproperty
	a_cmd_sample: assert property (p_cmd_sample) else $error("input bit not sampled");

	property p_dual_out;
		@(posedge clk_sys) disable iff (srst)
		serial_in_io0_oe |-> cmd_q == dual_output_fast_read && serial_out_io1_oe;
	endproperty
	a_dual_out: assert property (p_dual_out) else $error("io0 driven outside dual read");

	property p_desel_hiz;
		@(posedge clk_sys) disable iff (srst)
		pins_s.cs_n |-> !serial_out_io1_oe && !serial_in_io0_oe;
	endproperty
	a_desel_hiz: assert property (p_desel_hiz) else $error("driving while deselected");

	property p_unarmed;
		@(posedge clk_sys) disable iff (srst)
		!armed_q |-> !op_valid ##1 !op_valid;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("op before first select fall");

	property p_pause_hiz;
		@(posedge clk_sys) disable iff (srst)
		paused |-> !serial_out_io1_oe && !serial_in_io0_oe && selected;
	endproperty
	a_pause_hiz: assert property (p_pause_hiz) else $error("driving while paused");

	property p_freeze;
		@(posedge clk_sys) disable iff (srst)
		srwd_q && !pins_s.wp_n |=> $stable(bp_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("protect bits changed while frozen");

	property p_stay_active;
		@(posedge clk_sys) disable iff (srst)
		!selected && busy_flag && !deep_q |=> power_state == pwr_active;
	endproperty
	a_stay_active: assert property (p_stay_active) else $error("standby while busy");

	property p_deep_ignore;
		@(posedge clk_sys) disable iff (srst)
		deep_q && $past(deep_q) |-> !op_valid;
	endproperty
	a_deep_ignore: assert property (p_deep_ignore) else $error("op in deep sleep");

	property p_mod8;
		@(posedge clk_sys) disable iff (srst)
		op_valid |-> $past(pulse_q) == 3'h0 && $past(cs_rise);
	endproperty
	a_mod8: assert property (p_mod8) else $error("op on partial byte count");

	property p_wel_clear;
		@(posedge clk_sys) disable iff (srst)
		op_valid |-> !wel_q ##1 !wel_q;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch kept after op");

	property p_busy_reject;
		@(posedge clk_sys) disable iff (srst)
		op_valid |-> !$past(busy_flag);
	endproperty
	a_busy_reject: assert property (p_busy_reject) else $error("op taken while busy");
endmodule // spi_flash_front_end

// ### inc/spi_flash_pkg.sv
package spi_flash_pkg;
	// Frame geometry
	localparam int addr_bytes = 3;
	localparam int page_bytes = 256;
	localparam int dummy_clocks = 8;

	// Instruction codes
	localparam logic [7:0] write_enable_cmd = 8'h06;
	localparam logic [7:0] write_disable_cmd = 8'h04;
	localparam logic [7:0] read_status_cmd = 8'h05;
	localparam logic [7:0] status_write_cmd = 8'h01;
	localparam logic [7:0] read_cmd = 8'h03;
	localparam logic [7:0] fast_read_cmd = 8'h0B;
	localparam logic [7:0] dual_output_fast_read = 8'h3B;
	localparam logic [7:0] page_program_cmd = 8'h02;
	localparam logic [7:0] dual_input_program = 8'hA2;
	localparam logic [7:0] otp_program_cmd = 8'h42;
	localparam logic [7:0] subsector_erase_cmd = 8'h20;
	localparam logic [7:0] sector_erase_cmd = 8'hD8;
	localparam logic [7:0] whole_array_erase_cmd = 8'hC7;
	localparam logic [7:0] deep_sleep_cmd = 8'hB9;
	localparam logic [7:0] wake_from_deep_sleep_cmd = 8'hAB;

	// Status byte layout and reset values
	localparam int st_busy_bit = 0;
	localparam int st_wel_bit = 1;
	localparam int st_bp_lsb = 2;
	localparam int st_srwd_bit = 7;
	localparam logic [2:0] bp_reset = 3'h0;
	localparam logic srwd_reset = 1'b0;

	// Idle levels of the synchronised pins: cs_n, sclk, hold_n, wp_n, io0, io1
	localparam logic [5:0] pins_idle = 6'h2C;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic hold_n;
		logic wp_n;
		logic io0;
		logic io1;
	} pins_t;

	typedef enum logic [2:0] {ph_cmd, ph_addr, ph_dummy, ph_din, ph_dout, ph_done} phase_t;

	typedef enum logic [2:0] {
		op_none, op_page_prog, op_otp_prog, op_subsector_erase,
		op_sector_erase, op_array_erase, op_status_write
	} op_kind_t;

	typedef enum logic [1:0] {pwr_standby, pwr_active, pwr_deep} power_t;

	typedef struct packed {
		op_kind_t kind;
		logic [23:0] addr;
		logic [7:0] data;
	} mem_op_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] data;
	} wr_byte_t;
endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for a group of pins
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] sync_q
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end
endmodule // pin_sync

// ### verification/host_model.sv
`timescale 1ns/10ps
// Host controller stand-in: drives select, clock, pause and the data pins
module host_model (
	output logic cs_n,
	output logic sclk,
	output logic hold_n,
	output logic io0_d,
	output logic io0_en,
	output logic io1_d,
	output logic io1_en,
	input wire logic io0_pin,
	input wire logic io1_pin
);
	localparam time half = 100ns;
	logic idle_hi = 1'b0;
	// Idle pins: deselected, clock low, not paused
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		hold_n = 1'b1;
		io0_d = 1'b0;
		io0_en = 1'b1;
		io1_d = 1'b0;
		io1_en = 1'b0;
	end
	// Each frame opens with a select fall from the chosen idle clock level
	task automatic start(input logic mode3);
		idle_hi = mode3;
		sclk = mode3;
		#half;
		cs_n = 1'b0;
		#half;
	endtask
	// Runs nclk clocks, MSB first, two bits per clock in dual; md 0 single, 1 dual in, 2 dual out
	task automatic xfer(input logic [7:0] tx, input int md, input int nclk,
		output logic [7:0] rx);
		rx = 8'h00;
		io1_en = (md == 1);
		io0_en = (md != 2);
		for (int i = 0; i < nclk; i++) begin
			sclk = 1'b0;
			if (md == 0) io0_d = tx[7-i];
			else begin
				io1_d = tx[7-2*i];
				io0_d = tx[6-2*i];
			end
			#half;
			sclk = 1'b1;
			// Sample late in the high phase, after the device has settled
			#(half - 10ns);
			if (md == 0) rx[7-i] = io1_pin;
			else begin
				rx[7-2*i] = io1_pin;
				rx[6-2*i] = io0_pin;
			end
			#10ns;
		end
	endtask
	// Returns the clock to idle, then deselects half a period later, wherever the frame stands
	task automatic stop();
		#half;
		sclk = idle_hi;
		io1_en = 1'b0;
		io0_en = 1'b1;
		#half;
		cs_n = 1'b1;
		#(4*half);
	endtask
	// Pause only while selected
	task automatic pause(input logic on);
		if (!cs_n) hold_n = !on;
		#half;
	endtask
endmodule // host_model

// ### verification/spi_flash_front_end_bench.sv
`timescale 1ns/10ps
// Self-checking run of the front end against the host model and a small core
module spi_flash_front_end_bench;
	import spi_flash_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic core_busy = 1'b0;
	logic junk_q = 1'b0;
	logic wp_n = 1'b1;
	logic cs_n, sclk, hold_n, h0_d, h0_en, h1_d, h1_en, io0, io1;
	logic d0_o, d0_oe, d1_o, d1_oe, frame_start, wr_valid, op_valid;
	logic [23:0] rd_addr;
	logic [7:0] rd_data, status, rx;
	wr_byte_t wr_byte;
	wr_byte_t wq[$];
	mem_op_t op, last_op;
	power_t power_state;
	int num_errors = 0, comparisons = 0, n_ops = 0, busy_cnt = 0, n0;
	logic [7:0] ecmd[3] = '{subsector_erase_cmd, sector_erase_cmd, whole_array_erase_cmd};
	op_kind_t ekind[3] = '{op_subsector_erase, op_sector_erase, op_array_erase};
	// 40 MHz clock
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Released lines toggle so a stale value can never pass for data
	assign io0 = d0_oe ? d0_o : (h0_en ? h0_d : junk_q);
	assign io1 = d1_oe ? d1_o : (h1_en ? h1_d : junk_q);
	assign rd_data = rd_addr[7:0] ^ 8'h5A;
	// Core stand-in: logs commits and stays busy for a while after each
	always @(posedge clk_sys) begin
		if (op_valid === 1'b1) begin
			n_ops <= n_ops + 1;
			last_op <= op;
			busy_cnt <= 1500;
		end else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
		if (wr_valid === 1'b1) wq.push_back(wr_byte);
	end
	always @(negedge clk_sys) begin
		junk_q <= ~junk_q;
		core_busy <= (busy_cnt != 0);
	end
	host_model host_model_inst (.cs_n(cs_n), .sclk(sclk), .hold_n(hold_n), .io0_d(h0_d),
		.io0_en(h0_en), .io1_d(h1_d), .io1_en(h1_en), .io0_pin(io0), .io1_pin(io1));
	spi_flash_front_end spi_flash_front_end_inst (.clk_sys(clk_sys), .srst(srst),
		.cs_n(cs_n), .sclk(sclk), .hold_n(hold_n), .wp_n(wp_n), .serial_in_io0_i(io0),
		.serial_in_io0_o(d0_o), .serial_in_io0_oe(d0_oe), .serial_out_io1_i(io1),
		.serial_out_io1_o(d1_o), .serial_out_io1_oe(d1_oe), .core_busy(core_busy),
		.rd_data(rd_data), .rd_addr(rd_addr), .frame_start(frame_start),
		.wr_valid(wr_valid), .wr_byte(wr_byte), .op_valid(op_valid), .op(op),
		.status(status), .power_state(power_state));
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic send(input logic [7:0] b);
		host_model_inst.xfer(b, 0, 8, rx);
	endtask
	task automatic simple(input logic [7:0] c);
		host_model_inst.start(1'b0);
		send(c);
		host_model_inst.stop();
	endtask
	// Opcode and three address bytes; the caller ends the frame
	task automatic addr_cmd(input logic [7:0] c, input logic [23:0] a);
		host_model_inst.start(1'b0);
		send(c);
		send(a[23:16]);
		send(a[15:8]);
		send(a[7:0]);
	endtask
	task automatic rstat(input logic m3, input logic [7:0] m, input logic [7:0] exp);
		host_model_inst.start(m3);
		send(read_status_cmd);
		send(8'h00);
		host_model_inst.stop();
		check(rx & m, exp);
	endtask
	// Bounded wait for the core to finish its cycle
	task automatic wait_idle();
		int n;
		n = 0;
		while (core_busy !== 1'b0 && n < 4000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 4000) begin
			num_errors++;
			$display("BAD %0t core stayed busy", $time);
			give_verdict();
		end
		repeat (8) @(negedge clk_sys);
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		srst = 1'b0;
		repeat (4) @(negedge clk_sys);
		check(status, 8'h00);
		check(power_state, pwr_standby);
		check(d1_oe, 1'b0);
		rstat(1'b0, 8'hFF, 8'h00);
		// Program with the latch clear must not commit
		n0 = n_ops;
		addr_cmd(page_program_cmd, 24'h0012FE);
		send(8'h55);
		host_model_inst.stop();
		check(n_ops, n0);
		simple(write_enable_cmd);
		rstat(1'b1, 8'hFF, 8'h02);
		// Three bytes from the next to last byte of a page wrap inside it
		wq.delete();
		addr_cmd(page_program_cmd, 24'h0012FE);
		send(8'h55);
		send(8'hAA);
		send(8'h0F);
		host_model_inst.stop();
		check(last_op.kind, op_page_prog);
		check(wq.pop_front(), {24'h0012FE, 8'h55});
		check(wq.pop_front(), {24'h0012FF, 8'hAA});
		check(wq.pop_front(), {24'h001200, 8'h0F});
		check(power_state, pwr_active);
		rstat(1'b0, 8'h01, 8'h01);
		n0 = n_ops;
		simple(write_enable_cmd);
		addr_cmd(sector_erase_cmd, 24'h010000);
		host_model_inst.stop();
		check(n_ops, n0);
		wait_idle();
		check(power_state, pwr_standby);
		simple(write_disable_cmd);
		// Every erase kind after its own write enable
		for (int k = 0; k < 3; k++) begin
			n0 = n_ops;
			simple(write_enable_cmd);
			if (k == 2) simple(ecmd[k]);
			else begin
				addr_cmd(ecmd[k], 24'h034000);
				host_model_inst.stop();
			end
			check(n_ops, n0 + 1);
			check(last_op.kind, ekind[k]);
			wait_idle();
		end
		// A stray clock leaves the frame off a byte boundary
		simple(write_enable_cmd);
		n0 = n_ops;
		addr_cmd(sector_erase_cmd, 24'h020000);
		host_model_inst.xfer(8'h00, 0, 1, rx);
		host_model_inst.stop();
		check(n_ops, n0);
		rstat(1'b0, 8'hFF, 8'h02);
		wq.delete();
		addr_cmd(dual_input_program, 24'h000100);
		// Two dual bytes keep the clock count a whole multiple of eight
		host_model_inst.xfer(8'hC3, 1, 4, rx);
		host_model_inst.xfer(8'h96, 1, 4, rx);
		host_model_inst.stop();
		check(n_ops, n0 + 1);
		check(wq.pop_front(), {24'h000100, 8'hC3});
		check(wq.pop_front(), {24'h000101, 8'h96});
		wait_idle();
		addr_cmd(dual_output_fast_read, 24'h000040);
		send(8'h00);
		host_model_inst.xfer(8'h00, 2, 4, rx);
		check(rx, 8'h1A);
		check(d0_oe, 1'b1);
		host_model_inst.stop();
		check({d0_oe, d1_oe}, 2'b00);
		// Clocks during a pause are ignored and the read resumes intact
		host_model_inst.start(1'b0);
		repeat (4) @(negedge clk_sys);
		check(power_state, pwr_active);
		send(read_status_cmd);
		host_model_inst.pause(1'b1);
		repeat (6) @(negedge clk_sys);
		check(d1_oe, 1'b0);
		send(8'hFF);
		host_model_inst.pause(1'b0);
		send(8'h00);
		host_model_inst.stop();
		check(rx, 8'h00);
		simple(deep_sleep_cmd);
		check(power_state, pwr_deep);
		n0 = n_ops;
		simple(write_enable_cmd);
		addr_cmd(sector_erase_cmd, 24'h000000);
		host_model_inst.stop();
		check(n_ops, n0);
		simple(wake_from_deep_sleep_cmd);
		check(power_state == pwr_deep, 1'b0);
		rstat(1'b0, 8'hFF, 8'h00);
		// Set srwd and protect bits, then a low write-protect pin freezes them
		simple(write_enable_cmd);
		host_model_inst.start(1'b0);
		send(status_write_cmd);
		send(8'h8C);
		host_model_inst.stop();
		wait_idle();
		rstat(1'b0, 8'hFC, 8'h8C);
		wp_n = 1'b0;
		simple(write_enable_cmd);
		host_model_inst.start(1'b0);
		send(status_write_cmd);
		send(8'h00);
		host_model_inst.stop();
		wait_idle();
		rstat(1'b0, 8'hFC, 8'h8C);
		give_verdict();
	end
endmodule // spi_flash_front_end_bench
